//--- fbp_pkg.sv
package fbp_pkg;

  // ==========================================================================
  // Geometry
  localparam int unsigned PIN_N = 4;
  localparam int unsigned MODE_W = 2;
  localparam int unsigned STAT_W = 4;

  // ==========================================================================
  // Register addresses (byte addresses on the plain port)
  localparam logic [7:0] ADDR_OUT_VALUE = 8'h0B;
  localparam logic [7:0] ADDR_MODE_LOW = 8'h2E;
  localparam logic [7:0] ADDR_MODE_HIGH = 8'h2F;
  localparam logic [7:0] ADDR_DIRECTION = 8'h30;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h31;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h32;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h33;

  // ==========================================================================
  // Reset values and field positions
  localparam logic [3:0] RST_REG = 4'h0;
  localparam logic [3:0] ALL_OUTPUT = 4'hF;
  localparam logic [3:0] RD_NONE = 4'h0;
  localparam int unsigned STAT_EXT0 = 0;
  localparam int unsigned MODE_LO_BIT = 0;
  localparam int unsigned MODE_HI_BIT = 1;

  // ==========================================================================
  // Output drive types; input pull uses the same field
  typedef enum logic [1:0] {
    FBP_OUT_CMOS = 2'b00,
    FBP_OUT_NOD = 2'b01,
    FBP_OUT_POD = 2'b10,
    FBP_OUT_HIZ = 2'b11
  } fbp_omode_e;

  localparam logic [1:0] IN_PULL_DOWN = 2'b00;
  localparam logic [1:0] IN_PULL_UP = 2'b10;

endpackage : fbp_pkg

//--- fbp_top.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module fbp_top #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [3:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [3:0] o_rdata,
  // Pins
  input wire logic [3:0] i_pin,
  output logic [3:0] o_pin_out,
  output logic [3:0] o_pin_oe_b,
  output logic [3:0] o_pull_up,
  output logic [3:0] o_pull_dn,
  // Interrupt
  output logic o_irq
);

  // ==========================================================================
  // Helpers
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] r);
    hit = (a == ADDR_W'(r));
  endfunction : hit

  function automatic logic [1:0] pin_mode(input logic [7:0] m, input int unsigned k);
    pin_mode = m[2*k +: 2];
  endfunction : pin_mode

  // Returns {oe_b, level}
  function automatic logic [1:0] drive(input logic dir, input logic dat,
                                       input logic [1:0] mode);
    logic [1:0] r;
    r = {1'b1, 1'b0};
    if (dir) begin
      case (fbp_pkg::fbp_omode_e'(mode))
        fbp_pkg::FBP_OUT_CMOS: r = {1'b0, dat};
        fbp_pkg::FBP_OUT_NOD: r = {dat, 1'b0};
        fbp_pkg::FBP_OUT_POD: r = {~dat, 1'b1};
        default: r = {1'b1, 1'b0};
      endcase
    end
    drive = r;
  endfunction : drive

  // Returns {up, down}
  function automatic logic [1:0] pulls(input logic dir, input logic [1:0] mode);
    logic [1:0] r;
    r = 2'b00;
    if (!dir && !mode[fbp_pkg::MODE_LO_BIT]) begin
      r = mode[fbp_pkg::MODE_HI_BIT] ? 2'b10 : 2'b01;
    end
    pulls = r;
  endfunction : pulls

  // ==========================================================================
  // Registers
  logic [3:0] out_q, out_d;
  logic [3:0] dir_q, dir_d;
  logic [3:0] mlo_q, mlo_d;
  logic [3:0] mhi_q, mhi_d;
  logic [3:0] ien_q, ien_d;
  logic [3:0] stat_q, stat_d;
  logic [3:0] msk_q, msk_d;
  logic ext0_prev_q;
  logic ext0_lvl;
  logic ext0_rise;
  logic [3:0] rd_mux;
  logic [7:0] mode_d;
  logic [3:0] pin_out_d, pin_oe_b_d, pull_up_d, pull_dn_d;

  // ==========================================================================
  // Write decode
  always_comb begin
    out_d = out_q;
    dir_d = dir_q;
    mlo_d = mlo_q;
    mhi_d = mhi_q;
    ien_d = ien_q;
    msk_d = msk_q;
    if (i_wr && hit(i_addr, fbp_pkg::ADDR_OUT_VALUE)) begin
      out_d = i_wdata;
    end else if (i_wr && hit(i_addr, fbp_pkg::ADDR_DIRECTION)) begin
      dir_d = i_wdata;
    end else if (i_wr && hit(i_addr, fbp_pkg::ADDR_MODE_LOW)) begin
      mlo_d = i_wdata;
    end else if (i_wr && hit(i_addr, fbp_pkg::ADDR_MODE_HIGH)) begin
      mhi_d = i_wdata;
    end else if (i_wr && hit(i_addr, fbp_pkg::ADDR_IRQ_ENABLE)) begin
      ien_d = i_wdata;
    end else if (i_wr && hit(i_addr, fbp_pkg::ADDR_IRQ_MASK)) begin
      msk_d = i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_q <= fbp_pkg::RST_REG;
    end else begin
      out_q <= out_d;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dir_q <= fbp_pkg::RST_REG;
    end else begin
      dir_q <= dir_d;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mlo_q <= fbp_pkg::RST_REG;
      mhi_q <= fbp_pkg::RST_REG;
    end else begin
      mlo_q <= mlo_d;
      mhi_q <= mhi_d;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ien_q <= fbp_pkg::RST_REG;
      msk_q <= fbp_pkg::RST_REG;
    end else begin
      ien_q <= ien_d;
      msk_q <= msk_d;
    end
  end

  // ==========================================================================
  // Pin drive, computed from next values so pins move with the register
  always_comb begin
    logic [1:0] dv;
    logic [1:0] pv;
    dv = 2'b00;
    pv = 2'b00;
    mode_d = {mhi_d, mlo_d};
    pin_out_d = '0;
    pin_oe_b_d = '0;
    pull_up_d = '0;
    pull_dn_d = '0;
    for (int unsigned k = 0; k < fbp_pkg::PIN_N; k++) begin
      dv = drive(dir_d[k], out_d[k], pin_mode(mode_d, k));
      pv = pulls(dir_d[k], pin_mode(mode_d, k));
      pin_oe_b_d[k] = dv[1];
      pin_out_d[k] = dv[0];
      pull_up_d[k] = pv[1];
      pull_dn_d[k] = pv[0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pin_out <= '0;
      o_pin_oe_b <= '1;
      o_pull_up <= '0;
      o_pull_dn <= '1;
    end else begin
      o_pin_out <= pin_out_d;
      o_pin_oe_b <= pin_oe_b_d;
      o_pull_up <= pull_up_d;
      o_pull_dn <= pull_dn_d;
    end
  end

  // ==========================================================================
  // External interrupt 0: rising edge of the enabled OR
  assign ext0_lvl = |(i_pin & ien_q);
  assign ext0_rise = ext0_lvl && !ext0_prev_q;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ext0_prev_q <= 1'b0;
    end else begin
      ext0_prev_q <= ext0_lvl;
    end
  end

  // Set beats read-clear so a coincident event is not lost
  always_comb begin
    stat_d = stat_q;
    if (i_rd && hit(i_addr, fbp_pkg::ADDR_IRQ_STATUS)) begin
      stat_d = '0;
    end
    stat_d[fbp_pkg::STAT_EXT0] = stat_d[fbp_pkg::STAT_EXT0] | ext0_rise;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_q <= fbp_pkg::RST_REG;
    end else begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(stat_d & msk_d);
    end
  end

  // ==========================================================================
  // Read path: data valid only in the cycle after the strobe
  always_comb begin
    rd_mux = fbp_pkg::RD_NONE;
    if (hit(i_addr, fbp_pkg::ADDR_OUT_VALUE)) begin
      rd_mux = (out_q & dir_q) | (i_pin & ~dir_q);
    end else if (hit(i_addr, fbp_pkg::ADDR_DIRECTION)) begin
      rd_mux = dir_q;
    end else if (hit(i_addr, fbp_pkg::ADDR_MODE_LOW)) begin
      rd_mux = mlo_q;
    end else if (hit(i_addr, fbp_pkg::ADDR_MODE_HIGH)) begin
      rd_mux = mhi_q;
    end else if (hit(i_addr, fbp_pkg::ADDR_IRQ_ENABLE)) begin
      rd_mux = ien_q;
    end else if (hit(i_addr, fbp_pkg::ADDR_IRQ_STATUS)) begin
      rd_mux = stat_q;
    end else if (hit(i_addr, fbp_pkg::ADDR_IRQ_MASK)) begin
      rd_mux = msk_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= fbp_pkg::RD_NONE;
    end else begin
      o_rdata <= i_rd ? rd_mux : fbp_pkg::RD_NONE;
    end
  end

  // ==========================================================================
  // Assertions
  property p_reset_clear;
    @(posedge i_mclk) disable iff (!i_rst_b)
    !$past(i_rst_b) |-> (out_q == 4'h0) && (dir_q == 4'h0) && (mlo_q == 4'h0)
      && (mhi_q == 4'h0) && (o_pin_oe_b == 4'hF) && (o_pull_dn == 4'hF);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("registers or pins not cleared after reset");

  property p_write_to_pin;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_wr && hit(i_addr, fbp_pkg::ADDR_OUT_VALUE) && dir_q == 4'hF
      && mlo_q == 4'h0 && mhi_q == 4'h0)
      |=> (o_pin_out == $past(i_wdata)) && (o_pin_oe_b == 4'h0);
  endproperty
  a_write_to_pin: assert property (p_write_to_pin)
    else $error("pins did not take written data at the next edge");

  property p_read_mix;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_rd && hit(i_addr, fbp_pkg::ADDR_OUT_VALUE))
      |=> o_rdata == (($past(out_q) & $past(dir_q)) | ($past(i_pin) & ~$past(dir_q)));
  endproperty
  a_read_mix: assert property (p_read_mix)
    else $error("data read does not mix stored bits and pin levels");

  property p_input_released;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (o_pin_oe_b | dir_q) == 4'hF;
  endproperty
  a_input_released: assert property (p_input_released)
    else $error("input pin is being driven");

  property p_cmos_drive;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (dir_q[0] && mlo_q[1:0] == 2'b00) |-> !o_pin_oe_b[0] && (o_pin_out[0] == out_q[0]);
  endproperty
  a_cmos_drive: assert property (p_cmos_drive)
    else $error("CMOS pin 0 not driven from data bit");

  property p_nod_drive;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (dir_q[1] && mlo_q[3:2] == 2'b01) |-> !o_pin_out[1] && (o_pin_oe_b[1] == out_q[1]);
  endproperty
  a_nod_drive: assert property (p_nod_drive)
    else $error("open drain pin 1 drives wrongly");

  property p_high_hiz;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (dir_q[2] && mhi_q[1:0] == 2'b11) |-> o_pin_oe_b[2] && !o_pull_up[2] && !o_pull_dn[2];
  endproperty
  a_high_hiz: assert property (p_high_hiz)
    else $error("pin 2 not released in high-impedance mode");

  property p_pull_sel;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (!dir_q[0] && mlo_q[1:0] == 2'b10) |-> o_pull_up[0] && !o_pull_dn[0];
  endproperty
  a_pull_sel: assert property (p_pull_sel)
    else $error("pin 0 pull-up not selected");

  property p_irq_event;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (ext0_lvl && !ext0_prev_q) |=> stat_q[0] && (o_irq || !msk_q[0]);
  endproperty
  a_irq_event: assert property (p_irq_event)
    else $error("enabled pin rise did not set interrupt status");

  property p_irq_disabled;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (ien_q == 4'h0 && !stat_q[0]) |=> !stat_q[0];
  endproperty
  a_irq_disabled: assert property (p_irq_disabled)
    else $error("disabled pins raised interrupt status");

  property p_pod_drive;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (dir_q[3] && mhi_q[3:2] == 2'b10) |-> o_pin_out[3] && (o_pin_oe_b[3] == !out_q[3]);
  endproperty
  a_pod_drive: assert property (p_pod_drive)
    else $error("P open drain pin 3 drives wrongly");

  property p_pull_down;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (!dir_q[1] && mlo_q[3:2] == 2'b00) |-> o_pull_dn[1] && !o_pull_up[1];
  endproperty
  a_pull_down: assert property (p_pull_down)
    else $error("pin 1 pull-down not selected");

  property p_input_float;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (!dir_q[3] && mhi_q[2]) |-> !o_pull_up[3] && !o_pull_dn[3];
  endproperty
  a_input_float: assert property (p_input_float)
    else $error("pin 3 pulled although floating input selected");

  property p_status_sticky;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (stat_q[0] && !(i_rd && hit(i_addr, fbp_pkg::ADDR_IRQ_STATUS))) |=> stat_q[0];
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("interrupt status dropped without a read");

  property p_status_clear;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_rd && hit(i_addr, fbp_pkg::ADDR_IRQ_STATUS) && !ext0_rise)
      |=> (stat_q == 4'h0) && !o_irq;
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status read did not clear status and interrupt");

  property p_read_status;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_rd && hit(i_addr, fbp_pkg::ADDR_IRQ_STATUS)) |=> o_rdata == $past(stat_q);
  endproperty
  a_read_status: assert property (p_read_status)
    else $error("status read returned wrong value");

endmodule : fbp_top

//--- fbp_pin_board.sv
`timescale 1ns/1ps
module fbp_pin_board (
  // Clock
  input wire logic i_mclk,
  // Device side of the pins
  input wire logic [3:0] i_pin_out,
  input wire logic [3:0] i_pin_oe_b,
  input wire logic [3:0] i_pull_up,
  input wire logic [3:0] i_pull_dn,
  // Board drivers
  input wire logic [3:0] i_ext_val,
  input wire logic [3:0] i_ext_en,
  // Resolved pin levels
  output logic [3:0] o_pin
);
  // ==========================================================================
  // Wire resolution
  logic [3:0] last_q = 4'h0;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (!i_pin_oe_b[k])
        o_pin[k] = i_pin_out[k];
      else if (i_ext_en[k])
        o_pin[k] = i_ext_val[k];
      else if (i_pull_up[k])
        o_pin[k] = 1'b1;
      else if (i_pull_dn[k])
        o_pin[k] = 1'b0;
      else
        // Floating pin wanders so a stale level never looks valid
        o_pin[k] = ~last_q[k];
    end
  end

  always_ff @(posedge i_mclk) begin
    last_q <= o_pin;
  end
endmodule : fbp_pin_board

//--- test_fbp_top.sv
`timescale 1ns/1ps
module test_fbp_top;
  // ==========================================================================
  // Signals
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [3:0] i_wdata = 4'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] o_rdata, pin, o_pin_out, o_pin_oe_b, o_pull_up, o_pull_dn;
  logic o_irq;
  logic [3:0] ext_val = 4'h0;
  logic [3:0] ext_en = 4'h0;
  logic [3:0] m;
  int error_cnt = 0;
  int comparisons = 0;

  fbp_top #(.ADDR_W(8)) u_fbp_top (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(pin),
    .o_pin_out(o_pin_out), .o_pin_oe_b(o_pin_oe_b), .o_pull_up(o_pull_up),
    .o_pull_dn(o_pull_dn), .o_irq(o_irq));

  fbp_pin_board u_fbp_pin_board (.i_mclk(i_mclk), .i_pin_out(o_pin_out),
    .i_pin_oe_b(o_pin_oe_b), .i_pull_up(o_pull_up), .i_pull_dn(o_pull_dn),
    .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pin(pin));

  initial begin
    forever #2.5 i_mclk = ~i_mclk;
  end

  // ==========================================================================
  // Helpers
  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Write stored at the second edge; outputs settled on return
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [3:0] exp);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask : rd_chk

  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (o_irq !== exp && n < 8) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk({3'h0, o_irq}, {3'h0, exp});
    if (o_irq !== exp)
      wrap_up();
  endtask : wait_irq

  // Board drivers move only at a rising edge, like every other input
  task automatic set_board(input logic [3:0] en, input logic [3:0] val);
    @(posedge i_mclk);
    ext_en <= en;
    ext_val <= val;
    #1;
  endtask : set_board

  // ==========================================================================
  // Sequence
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    #1;
    chk(o_pin_oe_b, 4'hF);
    chk(o_pull_dn, 4'hF);
    rd_chk(fbp_pkg::ADDR_OUT_VALUE, 4'h0);
    rd_chk(fbp_pkg::ADDR_DIRECTION, 4'h0);
    rd_chk(fbp_pkg::ADDR_MODE_LOW, 4'h0);
    rd_chk(fbp_pkg::ADDR_MODE_HIGH, 4'h0);
    rd_chk(8'h50, 4'h0);
    // Output drive types, data 0101 on all pins
    wr(fbp_pkg::ADDR_DIRECTION, 4'hF);
    wr(fbp_pkg::ADDR_OUT_VALUE, 4'h5);
    chk(o_pin_out, 4'h5);
    chk(o_pin_oe_b, 4'h0);
    // Board shows 0110 on every released pin
    set_board(4'hF, 4'h6);
    for (int i = 0; i < 4; i++) begin
      m = {i[1:0], i[1:0]};
      wr(fbp_pkg::ADDR_MODE_LOW, m);
      wr(fbp_pkg::ADDR_MODE_HIGH, m);
      case (i)
        0: chk({o_pin_out, o_pin_oe_b} , 8'h50);
        1: chk({o_pin_out, o_pin_oe_b} , 8'h05);
        2: chk({o_pin_out, o_pin_oe_b} , 8'hFA);
        default: chk(o_pin_oe_b, 4'hF);
      endcase
      chk(pin, (i == 0) ? 4'h5 : (i == 1) ? 4'h4 : (i == 2) ? 4'h7 : 4'h6);
    end
    // Mixed direction: low pins drive, high pins read the board
    wr(fbp_pkg::ADDR_MODE_LOW, 4'h0);
    wr(fbp_pkg::ADDR_MODE_HIGH, 4'h0);
    wr(fbp_pkg::ADDR_DIRECTION, 4'h3);
    set_board(4'hC, 4'hC);
    chk(o_pin_oe_b, 4'hC);
    rd_chk(fbp_pkg::ADDR_OUT_VALUE, 4'hD);
    set_board(4'hC, 4'h0);
    rd_chk(fbp_pkg::ADDR_OUT_VALUE, 4'h1);
    // Input pull selection per field value
    wr(fbp_pkg::ADDR_DIRECTION, 4'h0);
    chk(o_pull_dn, 4'hF);
    wr(fbp_pkg::ADDR_MODE_LOW, 4'h2);
    chk({o_pull_up, o_pull_dn}, 8'h1E);
    wr(fbp_pkg::ADDR_MODE_HIGH, 4'h8);
    chk({o_pull_up, o_pull_dn}, 8'h96);
    wr(fbp_pkg::ADDR_MODE_LOW, 4'h5);
    wr(fbp_pkg::ADDR_MODE_HIGH, 4'h5);
    chk({o_pull_up, o_pull_dn}, 8'h00);
    // Interrupt: only pin 0 enabled, mask off first
    set_board(4'hF, 4'h0);
    wr(fbp_pkg::ADDR_IRQ_ENABLE, 4'h1);
    set_board(4'hF, 4'h2);
    repeat (4) @(posedge i_mclk);
    rd_chk(fbp_pkg::ADDR_IRQ_STATUS, 4'h0);
    set_board(4'hF, 4'h3);
    repeat (4) @(posedge i_mclk);
    #1;
    chk({3'h0, o_irq}, 4'h0);
    wr(fbp_pkg::ADDR_IRQ_MASK, 4'h1);
    wait_irq(1'b1);
    rd_chk(fbp_pkg::ADDR_IRQ_STATUS, 4'h1);
    wait_irq(1'b0);
    rd_chk(fbp_pkg::ADDR_IRQ_STATUS, 4'h0);
    // Mid-run reset: every register and pin returns to its idle state
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    #1;
    chk({o_pin_oe_b, o_pull_dn}, 8'hFF);
    chk({o_pull_up, 3'h0, o_irq}, 8'h00);
    rd_chk(fbp_pkg::ADDR_MODE_HIGH, 4'h0);
    wr(fbp_pkg::ADDR_DIRECTION, 4'hF);
    rd_chk(fbp_pkg::ADDR_OUT_VALUE, 4'h0);
    chk({o_pin_out, o_pin_oe_b}, 8'h00);
    wrap_up();
  end
endmodule : test_fbp_top
